// ### inc/clkgen_pkg.sv
// constants for the loop bandwidth and base clock select block
package clkgen_pkg;
  localparam logic [11:0] OFS_CONTROL = 12'h000;
  localparam logic [11:0] OFS_BANDWIDTH = 12'h004;
  localparam logic [11:0] OFS_PROGRAM = 12'h008;
  // control register fields
  localparam int CTL_IRQ_EN = 7;
  localparam int CTL_FLAG = 6;
  localparam int CTL_ON = 5;
  localparam int CTL_BCS = 4;
  localparam logic [3:0] CTL_LOW_READ = 4'hf;
  // bandwidth register fields
  localparam int BW_AUTO = 7;
  localparam int BW_LOCK = 6;
  localparam int BW_TRACK = 5;
  // program register fields
  localparam int PRG_N_LSB = 4;
  localparam int PRG_L_LSB = 0;
  // reset values
  localparam logic [3:0] RST_MUL = 4'h6;
  localparam logic [3:0] RST_RANGE = 4'h1;
  localparam logic RST_ON = 1'b1;
  // source switch waits this many ticks of each clock
  localparam logic [1:0] SWITCH_TICKS = 2'h3;
  // frequency comparison window, in reference ticks
  localparam logic [7:0] WIN_TICKS = 8'h40;
  localparam logic [11:0] TOL_LOCK = 12'h002;
  localparam logic [11:0] TOL_UNLOCK = 12'h004;
  localparam logic [11:0] TOL_TRACK = 12'h004;
  localparam logic [11:0] TOL_UNTRACK = 12'h008;
  typedef enum logic [1:0] {
    SW_RUN = 2'b00,
    SW_DRAIN = 2'b01,
    SW_ARM = 2'b11
  } switch_state_t;
endpackage

// ### verilog/pll_bandwidth_and_base_clock_select.sv
// loop bandwidth control, lock detection and glitch-free base clock selection
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module pll_bandwidth_and_base_clock_select #(
  parameter logic [7:0] WIN = clkgen_pkg::WIN_TICKS,
  parameter logic [11:0] LOCK_TOL = clkgen_pkg::TOL_LOCK,
  parameter logic [11:0] UNLOCK_TOL = clkgen_pkg::TOL_UNLOCK,
  parameter logic [11:0] TRACK_TOL = clkgen_pkg::TOL_TRACK,
  parameter logic [11:0] UNTRACK_TOL = clkgen_pkg::TOL_UNTRACK
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic xtal_clock,
  input wire logic vco_clock,
  input wire logic stop_req,
  output logic base_clock_out,
  output logic clockgen_irq,
  output logic loop_enable,
  output logic filter_track,
  output logic vco_feedback_tick
);
  logic setup, access, wr, rd;
  logic hit_ctl, hit_bw, hit_prg, mapped;
  logic irq_en_q, irq_en_d, flag_q, flag_d, on_q, on_d, bcs_q, bcs_d;
  logic auto_q, auto_d, man_track_q, man_track_d;
  logic [3:0] mul_q, mul_d, range_q, range_d;
  logic [31:0] rdata_q, rdata_d;
  logic [3:0] n_eff;
  logic [3:0] fb_cnt_q, fb_cnt_d;
  logic fb_tick_q, fb_tick_d;
  logic [7:0] win_cnt_q, win_cnt_d;
  logic [11:0] vcnt_q, vcnt_d, expect_cnt, err;
  logic lock_q, lock_d, track_q, track_d;
  logic lock_shown;
  clkgen_pkg::switch_state_t sw_q, sw_d;
  logic src_q, src_d, target;
  logic [1:0] old_cnt_q, old_cnt_d, new_cnt_q, new_cnt_d;
  logic base_q, base_d;
  logic old_tick, new_tick, sel_tick;

  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign wr = access & pwrite;
  assign rd = access & ~pwrite;
  assign hit_ctl = paddr == clkgen_pkg::OFS_CONTROL;
  assign hit_bw = paddr == clkgen_pkg::OFS_BANDWIDTH;
  assign hit_prg = paddr == clkgen_pkg::OFS_PROGRAM;
  assign mapped = hit_ctl | hit_bw | hit_prg;
  // always ready: one access cycle per transfer
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;
  assign prdata = rdata_q;

  // the lock bit reads as zero outside automatic mode
  assign lock_shown = auto_q & lock_q;
  assign loop_enable = on_q & (range_q != 4'h0);

  // register file
  always_comb begin
    irq_en_d = irq_en_q;
    flag_d = flag_q;
    on_d = on_q;
    bcs_d = bcs_q;
    auto_d = auto_q;
    man_track_d = man_track_q;
    mul_d = mul_q;
    range_d = range_q;
    // a read clears the flag, but a toggle in the same cycle wins
    if (rd && hit_ctl) begin
      flag_d = 1'b0;
    end
    if (wr && hit_ctl) begin
      if (auto_q) begin
        irq_en_d = pwdata[clkgen_pkg::CTL_IRQ_EN];
      end
      // checks use the present values; a write of loop off with source on, made while the loop is on and the source off, or the reverse, moves both together
      if (pwdata[clkgen_pkg::CTL_ON] || !bcs_q) begin
        on_d = pwdata[clkgen_pkg::CTL_ON];
      end
      if (!pwdata[clkgen_pkg::CTL_BCS]) begin
        bcs_d = 1'b0;
      end else if (on_q && range_q != 4'h0) begin
        bcs_d = 1'b1;
      end
    end
    if (wr && hit_bw) begin
      auto_d = pwdata[clkgen_pkg::BW_AUTO];
      // kept while automatic, restored when manual resumes
      if (!auto_q) begin
        man_track_d = pwdata[clkgen_pkg::BW_TRACK];
      end
    end
    if (wr && hit_prg) begin
      mul_d = pwdata[clkgen_pkg::PRG_N_LSB +: 4];
      range_d = pwdata[clkgen_pkg::PRG_L_LSB +: 4];
    end
    if (auto_q && lock_d != lock_q) begin
      flag_d = 1'b1;
    end
    if (!auto_q) begin
      flag_d = 1'b0;
      irq_en_d = 1'b0;
    end
    if (stop_req || range_d == 4'h0) begin
      bcs_d = 1'b0;
    end
  end

  // read data is captured in the setup cycle
  always_comb begin
    rdata_d = rdata_q;
    if (setup && !pwrite) begin
      rdata_d = 32'h0000_0000;
      if (hit_ctl) begin
        rdata_d[clkgen_pkg::CTL_IRQ_EN] = irq_en_q;
        rdata_d[clkgen_pkg::CTL_FLAG] = flag_q;
        rdata_d[clkgen_pkg::CTL_ON] = on_q;
        rdata_d[clkgen_pkg::CTL_BCS] = bcs_q;
        rdata_d[3:0] = clkgen_pkg::CTL_LOW_READ;
      end else if (hit_bw) begin
        rdata_d[clkgen_pkg::BW_AUTO] = auto_q;
        rdata_d[clkgen_pkg::BW_LOCK] = lock_shown;
        rdata_d[clkgen_pkg::BW_TRACK] = filter_track;
      end else if (hit_prg) begin
        rdata_d[clkgen_pkg::PRG_N_LSB +: 4] = mul_q;
        rdata_d[clkgen_pkg::PRG_L_LSB +: 4] = range_q;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_q <= 1'b0;
      flag_q <= 1'b0;
      on_q <= clkgen_pkg::RST_ON;
      bcs_q <= 1'b0;
      auto_q <= 1'b0;
      man_track_q <= 1'b0;
      mul_q <= clkgen_pkg::RST_MUL;
      range_q <= clkgen_pkg::RST_RANGE;
      rdata_q <= 32'h0000_0000;
    end else begin
      irq_en_q <= irq_en_d;
      flag_q <= flag_d;
      on_q <= on_d;
      bcs_q <= bcs_d;
      auto_q <= auto_d;
      man_track_q <= man_track_d;
      mul_q <= mul_d;
      range_q <= range_d;
      rdata_q <= rdata_d;
    end
  end

  assign clockgen_irq = auto_q & irq_en_q & flag_q;
  assign filter_track = auto_q ? track_q : man_track_q;
  assign vco_feedback_tick = fb_tick_q;

  // feedback divider and frequency comparison
  assign n_eff = (mul_q == 4'h0) ? 4'h1 : mul_q;
  // widen before the product so a large multiplier times the window cannot wrap
  assign expect_cnt = 12'(n_eff) * 12'(WIN);
  assign err = (vcnt_q > expect_cnt) ? vcnt_q - expect_cnt : expect_cnt - vcnt_q;

  always_comb begin
    fb_cnt_d = fb_cnt_q;
    fb_tick_d = 1'b0;
    win_cnt_d = win_cnt_q;
    vcnt_d = vcnt_q;
    lock_d = lock_q;
    track_d = track_q;
    if (!loop_enable) begin
      fb_cnt_d = 4'h0;
      win_cnt_d = 8'h00;
      vcnt_d = 12'h000;
      lock_d = 1'b0;
      track_d = 1'b0;
    end else begin
      if (vco_clock) begin
        vcnt_d = vcnt_q + 12'h001;
        if (fb_cnt_q + 4'h1 >= n_eff) begin
          fb_cnt_d = 4'h0;
          fb_tick_d = 1'b1;
        end else begin
          fb_cnt_d = fb_cnt_q + 4'h1;
        end
      end
      if (xtal_clock) begin
        if (win_cnt_q + 8'h01 >= WIN) begin
          win_cnt_d = 8'h00;
          vcnt_d = 12'h000;
          // separate set and clear thresholds give hysteresis
          if (err <= LOCK_TOL) begin
            lock_d = 1'b1;
          end else if (err > UNLOCK_TOL) begin
            lock_d = 1'b0;
          end
          if (err <= TRACK_TOL) begin
            track_d = 1'b1;
          end else if (err > UNTRACK_TOL) begin
            track_d = 1'b0;
          end
        end else begin
          win_cnt_d = win_cnt_q + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fb_cnt_q <= 4'h0;
      fb_tick_q <= 1'b0;
      win_cnt_q <= 8'h00;
      vcnt_q <= 12'h000;
      lock_q <= 1'b0;
      track_q <= 1'b0;
    end else begin
      fb_cnt_q <= fb_cnt_d;
      fb_tick_q <= fb_tick_d;
      win_cnt_q <= win_cnt_d;
      vcnt_q <= vcnt_d;
      lock_q <= lock_d;
      track_q <= track_d;
    end
  end

  // source switch: stop on the old clock, then start on the new one
  assign target = bcs_q & loop_enable;
  assign old_tick = src_q ? vco_clock : xtal_clock;
  assign new_tick = src_q ? xtal_clock : vco_clock;
  assign sel_tick = src_q ? vco_clock : xtal_clock;

  always_comb begin
    sw_d = sw_q;
    src_d = src_q;
    old_cnt_d = old_cnt_q;
    new_cnt_d = new_cnt_q;
    base_d = base_q;
    unique case (sw_q)
      clkgen_pkg::SW_RUN: begin
        if (sel_tick) begin
          base_d = ~base_q;
        end
        if (target != src_q) begin
          sw_d = clkgen_pkg::SW_DRAIN;
          old_cnt_d = 2'h0;
          new_cnt_d = 2'h0;
        end
      end
      clkgen_pkg::SW_DRAIN: begin
        // output frozen; old source must tick SWITCH_TICKS times first
        if (old_tick) begin
          if (old_cnt_q + 2'h1 >= clkgen_pkg::SWITCH_TICKS) begin
            sw_d = clkgen_pkg::SW_ARM;
          end else begin
            old_cnt_d = old_cnt_q + 2'h1;
          end
        end
      end
      clkgen_pkg::SW_ARM: begin
        if (new_tick) begin
          if (new_cnt_q + 2'h1 >= clkgen_pkg::SWITCH_TICKS) begin
            sw_d = clkgen_pkg::SW_RUN;
            src_d = ~src_q;
          end else begin
            new_cnt_d = new_cnt_q + 2'h1;
          end
        end
      end
      default: begin
        sw_d = clkgen_pkg::SW_RUN;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_q <= clkgen_pkg::SW_RUN;
      src_q <= 1'b0;
      old_cnt_q <= 2'h0;
      new_cnt_q <= 2'h0;
      base_q <= 1'b0;
    end else begin
      sw_q <= sw_d;
      src_q <= src_d;
      old_cnt_q <= old_cnt_d;
      new_cnt_q <= new_cnt_d;
      base_q <= base_d;
    end
  end

  assign base_clock_out = base_q;
endmodule
`default_nettype wire

// ### testbench/pll_bandwidth_and_base_clock_select_checker.sv
// port-level assertions for the loop bandwidth and base clock select block
`timescale 1ns/1ns
`default_nettype none
module pll_bandwidth_and_base_clock_select_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic xtal_clock,
  input wire logic vco_clock,
  input wire logic base_clock_out,
  input wire logic clockgen_irq,
  input wire logic loop_enable,
  input wire logic filter_track,
  input wire logic vco_feedback_tick
);
  logic wr, mapped, rd_setup;
  // shadow: 6 auto, 5 manual filter bit, 4 irq enable, 3:0 range
  logic [6:0] sh_q, sh_d;
  assign wr = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign mapped = paddr == clkgen_pkg::OFS_CONTROL || paddr == clkgen_pkg::OFS_BANDWIDTH
    || paddr == clkgen_pkg::OFS_PROGRAM;
  always_comb begin
    sh_d = sh_q;
    if (wr && paddr == clkgen_pkg::OFS_BANDWIDTH) begin
      sh_d[6] = pwdata[7];
      // a write made while already in auto leaves the stored manual bit alone
      if (!sh_q[6]) sh_d[5] = pwdata[5];
    end
    if (wr && paddr == clkgen_pkg::OFS_CONTROL && sh_q[6]) sh_d[4] = pwdata[7];
    // enable is held clear for as long as manual mode lasts
    if (!sh_q[6]) sh_d[4] = 1'b0;
    if (wr && paddr == clkgen_pkg::OFS_PROGRAM) sh_d[3:0] = pwdata[3:0];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sh_q <= {3'h0, clkgen_pkg::RST_RANGE};
    else sh_q <= sh_d;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_slave_error: assert property (psel && penable |-> pslverr == !mapped)
    else $error("bad pslverr");
  a_read_hold: assert property ($changed(prdata) |-> $past(rd_setup))
    else $error("prdata moved without read");
  a_manual_quiet: assert property (!sh_q[6] |-> !clockgen_irq)
    else $error("irq in manual mode");
  a_irq_cause: assert property (clockgen_irq |-> sh_q[4] && sh_q[6])
    else $error("irq without enable");
  a_range_zero: assert property (sh_q[3:0] == 4'h0 |-> !loop_enable)
    else $error("loop on with zero range");
  a_manual_filter: assert property (!sh_q[6] |-> filter_track == sh_q[5])
    else $error("manual filter ignored");
  a_base_tick: assert property ($changed(base_clock_out) |-> $past(xtal_clock) || $past(vco_clock))
    else $error("base clock moved without tick");
  a_feedback_tick: assert property ($rose(vco_feedback_tick) |-> $past(vco_clock))
    else $error("feedback tick without vco tick");
endmodule
bind pll_bandwidth_and_base_clock_select pll_bandwidth_and_base_clock_select_checker u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pslverr, .xtal_clock,
  .vco_clock, .base_clock_out, .clockgen_irq, .loop_enable, .filter_track, .vco_feedback_tick);
`default_nettype wire

// ### testbench/clock_far_side.sv
// tick sources and a base clock consumer timing its edges
`timescale 1ns/1ns
`default_nettype none
module clock_far_side #(
  parameter int XP = 4,
  parameter int VP = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic base_clock_out,
  output logic xtal_clock,
  output logic vco_clock,
  output logic [7:0] gap
);
  logic [7:0] xc, vc, cnt;
  logic last;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xc <= 8'h00;
      vc <= 8'h00;
      cnt <= 8'h00;
      gap <= 8'h00;
      last <= 1'b0;
    end else begin
      xc <= (xc >= 8'(XP - 1)) ? 8'h00 : xc + 8'h01;
      vc <= (vc >= 8'(VP - 1)) ? 8'h00 : vc + 8'h01;
      last <= base_clock_out;
      cnt <= (last != base_clock_out) ? 8'h01 : cnt + 8'h01;
      // cycles between base edges, read by the bench
      if (last != base_clock_out) gap <= cnt;
    end
  end
  assign xtal_clock = xc == 8'h00;
  assign vco_clock = vc == 8'h00;
endmodule
`default_nettype wire

// ### testbench/pll_bandwidth_and_base_clock_select_bench.sv
// self-checking bench: apb traffic, tick sources, base clock timing
`timescale 1ns/1ns
`default_nettype none
module pll_bandwidth_and_base_clock_select_bench;
  localparam int XP = 4;
  localparam int VP = 2;
  localparam logic [11:0] CT = clkgen_pkg::OFS_CONTROL;
  localparam logic [11:0] BW = clkgen_pkg::OFS_BANDWIDTH;
  localparam logic [11:0] PG = clkgen_pkg::OFS_PROGRAM;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, stop_req = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, g;
  logic pready, pslverr, err, base_clock_out, clockgen_irq, loop_enable, filter_track;
  logic vco_feedback_tick, xtal_clock, vco_clock;
  logic [7:0] gap;
  logic [3:0] n;
  int error_cnt = 0, samples_checked = 0;
  initial forever #20 pclk = ~pclk;
  pll_bandwidth_and_base_clock_select #(.WIN(8'h08)) dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .xtal_clock, .vco_clock, .stop_req, .base_clock_out,
    .clockgen_irq, .loop_enable, .filter_track, .vco_feedback_tick);
  clock_far_side #(.XP(XP), .VP(VP)) far (.pclk, .presetn, .base_clock_out, .xtal_clock, .vco_clock, .gap);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // idle edge first, so a release and the next setup never share a step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a slave that never answers
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic fb_gap();
    int k;
    for (k = 0; k < 200 && vco_feedback_tick !== 1'b1; k++) @(posedge pclk);
    @(posedge pclk);
    for (k = 1; k < 200 && vco_feedback_tick !== 1'b1; k++) @(posedge pclk);
    g = 32'(k);
  endtask
  function automatic logic [31:0] fb_exp(input logic [3:0] m);
    return (m == 4'h0) ? 32'(VP) : 32'(VP) * {28'h0, m};
  endfunction
  task automatic wait_irq();
    for (int k = 0; k < 600 && clockgen_irq !== 1'b1; k++) @(posedge pclk);
  endtask
  task automatic results();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #(40 * 20000);
    error_cnt++;
    results();
  end
  initial begin
    void'($urandom(32'h7f98526f));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rdc(CT, 32'h2f);
    rdc(BW, 32'h0);
    rdc(PG, 32'h61);
    apb(1'b1, 12'h00c, $urandom);
    chk(32'(err), 32'h1);
    rdc(12'h00c, 32'h0);
    apb(1'b1, BW, 32'h20);
    @(posedge pclk);
    chk(32'(filter_track), 32'h1);
    rdc(BW, 32'h20);
    apb(1'b1, BW, 32'h0);
    chk(32'(gap), 32'(XP));
    apb(1'b1, CT, 32'h0);
    apb(1'b1, CT, 32'h10);
    rdc(CT, 32'h0f);
    apb(1'b1, CT, 32'h30);
    rdc(CT, 32'h2f);
    repeat (20) @(posedge pclk);
    apb(1'b1, BW, 32'h20);
    repeat (20) @(posedge pclk);
    apb(1'b1, CT, 32'h30);
    apb(1'b1, CT, 32'h10);
    rdc(CT, 32'h3f);
    repeat (40) @(posedge pclk);
    chk(32'(gap), 32'(VP));
    stop_req <= 1'b1;
    @(posedge pclk);
    stop_req <= 1'b0;
    rdc(CT, 32'h2f);
    repeat (40) @(posedge pclk);
    chk(32'(gap), 32'(XP));
    apb(1'b1, PG, 32'h60);
    @(posedge pclk);
    chk(32'(loop_enable), 32'h0);
    apb(1'b1, CT, 32'h30);
    rdc(CT, 32'h2f);
    for (int i = 0; i < 6; i++) begin
      n = (i == 0) ? 4'h0 : 4'($urandom);
      apb(1'b1, PG, {24'h0, n, 4'h1});
      rdc(PG, {24'h0, n, 4'h1});
      fb_gap();
      fb_gap();
      chk(g, fb_exp(n));
    end
    apb(1'b1, BW, 32'h0);
    apb(1'b1, PG, 32'h51);
    repeat (100) @(posedge pclk);
    apb(1'b1, BW, 32'h80);
    apb(1'b1, CT, 32'ha0);
    apb(1'b1, PG, 32'h21);
    wait_irq();
    chk(32'(clockgen_irq), 32'h1);
    rdc(CT, 32'hef);
    @(posedge pclk);
    chk(32'(clockgen_irq), 32'h0);
    rdc(BW, 32'he0);
    apb(1'b1, CT, 32'hb0);
    apb(1'b1, PG, 32'h51);
    wait_irq();
    rdc(BW, 32'h80);
    apb(1'b1, CT, 32'h80);
    apb(1'b1, BW, 32'h0);
    @(posedge pclk);
    chk(32'(clockgen_irq), 32'h0);
    rdc(CT, 32'h2f);
    results();
  end
endmodule
`default_nettype wire
